// ### verilog/gps_pkg.sv
// Package: constants shared by the port set block
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package gps_pkg;
	localparam int GPS_NGRP = 11;
	localparam int GPS_NBIDIR = 5;
	localparam logic [3:0] GRP_A = 4'h0;
	localparam logic [3:0] GRP_B = 4'h1;
	localparam logic [3:0] GRP_C = 4'h2;
	localparam logic [3:0] GRP_D = 4'h3;
	localparam logic [3:0] GRP_F = 4'h4;
	localparam logic [3:0] GRP_K = 4'h5;
	localparam logic [3:0] GRP_SINGLE = 4'hA;
	// Register byte addresses
	localparam logic [7:0] ADDR_GRP_LAST = 8'h28;
	localparam logic [7:0] ADDR_BIT_SET = 8'h40;
	localparam logic [7:0] ADDR_BIT_CLR = 8'h44;
	localparam logic [7:0] ADDR_BIT_TEST = 8'h48;
	localparam logic [7:0] ADDR_ALT_CTRL = 8'h4C;
	// Bit operation word fields
	localparam int FLD_GRP_LSB = 0;
	localparam int FLD_BIT_LSB = 4;
	// Alternate function enable bits
	localparam int ALT_PWM6 = 0;
	localparam int ALT_PWM_WIDE = 1;
	localparam int ALT_SQR = 2;
	localparam int ALT_SER = 3;
	localparam logic [3:0] ALT_RESET = 4'h0;
	// Reset values and latch masks
	localparam logic [3:0] LV_RESET = 4'hF;
	localparam logic [3:0] OUT_RESET = 4'h0;
	localparam logic [3:0] SINGLE_MASK = 4'h1;
	localparam logic [3:0] NIB_MASK = 4'hF;
	localparam logic [5:0] SEL_RESET = 6'h00;
endpackage : gps_pkg

// ### verilog/gps_port_set.sv
// Port set: latches, pin drivers, shared functions and APB slave
module gps_port_set
	import gps_pkg::*;
#(
	parameter logic CD_RESET_HIGH = 1'b0,
	parameter logic [19:0] BIDIR_PULL_OPT = 20'h00000,
	parameter logic [20:0] OUT_PULL_OPT = 21'h00000,
	parameter logic ZC_SEL = 1'b0
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [19:0] BIDIR_IN,
	output logic [19:0] BIDIR_OUT,
	output logic [19:0] BIDIR_OE,
	output logic [19:0] BIDIR_PULL,
	output logic [20:0] OUT_OUT,
	output logic [20:0] OUT_OE,
	output logic [20:0] OUT_PULL,
	input wire logic ZC_IN,
	input wire logic PWM6,
	input wire logic PWM_WIDE,
	input wire logic SQR_WAVE,
	input wire logic SER_SO,
	input wire logic SER_SCK,
	output logic SER_SI,
	output logic EXT_IRQ0,
	output logic EXT_IRQ1,
	output logic STANDBY_REL,
	output logic [7:0] ANALOG_FREE
);

	//////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic logic [3:0] gps_rst_val(input int g);
		if (g < 2 || g == 4) begin
			return LV_RESET;
		end else if (g < 4) begin
			return {4{CD_RESET_HIGH}};
		end else begin
			return OUT_RESET;
		end
	endfunction : gps_rst_val

	function automatic logic [3:0] gps_mask(input int g);
		return (g == int'(GRP_SINGLE)) ? SINGLE_MASK : NIB_MASK;
	endfunction : gps_mask

	function automatic logic gps_is_lv(input int g);
		return (g < 2 || g == 4);
	endfunction : gps_is_lv

	//////////////////////////////////////////////////////////////////////////
	// State

	logic [3:0] lat [0:GPS_NGRP-1];
	logic [19:0] pin_s1;
	logic [19:0] pin_s2;
	logic zc_s1;
	logic zc_s2;
	logic [3:0] alt;
	logic [5:0] test_sel;
	logic [3:0] grp_view [0:GPS_NGRP-1];
	logic [19:0] eff;

	//////////////////////////////////////////////////////////////////////////
	// APB decode

	wire logic acc = PSEL & PENABLE & PREADY;
	wire logic wr = acc & PWRITE;
	wire logic [7:0] off = PADDR;
	wire logic [3:0] gi = off[5:2];
	wire logic is_grp = (off <= ADDR_GRP_LAST) && (off[1:0] == 2'b00);
	wire logic is_set = (off == ADDR_BIT_SET);
	wire logic is_clr = (off == ADDR_BIT_CLR);
	wire logic is_tst = (off == ADDR_BIT_TEST);
	wire logic is_alt = (off == ADDR_ALT_CTRL);
	wire logic mapped = is_grp | is_set | is_clr | is_tst | is_alt;
	wire logic [3:0] op_grp = PWDATA[FLD_GRP_LSB +: 4];
	wire logic [1:0] op_bit = PWDATA[FLD_BIT_LSB +: 2];
	wire logic wr_grp = wr & is_grp;
	wire logic wr_set = wr & is_set;
	wire logic wr_clr = wr & is_clr;
	wire logic [3:0] tst_grp = test_sel[3:0];
	wire logic [1:0] tst_bit = test_sel[5:4];
	// Out-of-range group selects read as a clear pin
	wire logic test_bit = (tst_grp < 4'(GPS_NGRP)) ?
		grp_view[tst_grp][tst_bit] : 1'b0;
	wire logic [3:0] grp_rd = grp_view[gi];
	wire logic first_ext_irq_pin_src = ZC_SEL ? zc_s2 : pin_s2[19];

	//////////////////////////////////////////////////////////////////////////
	// Read view: pins for bidirectional, latch for output-only

	always_comb begin
		for (int g = 0; g < GPS_NGRP; g++) begin
			if (g < GPS_NBIDIR) begin
				grp_view[g] = pin_s2[g*4 +: 4];
			end else begin
				grp_view[g] = lat[g] & gps_mask(g);
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Effective output value with alternate functions

	always_comb begin
		for (int g = 0; g < GPS_NBIDIR; g++) begin
			eff[g*4 +: 4] = lat[g];
		end
		// A peripheral owns its pin only while enabled
		if (alt[ALT_PWM6]) begin
			eff[4] = PWM6;
		end
		if (alt[ALT_PWM_WIDE]) begin
			eff[5] = PWM_WIDE;
		end
		if (alt[ALT_SQR]) begin
			eff[6] = SQR_WAVE;
		end
		if (alt[ALT_SER]) begin
			eff[17] = SER_SO;
			eff[18] = SER_SCK;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Output latches

	always_ff @(posedge CLOCK) begin
		for (int g = 0; g < GPS_NGRP; g++) begin
			if (RST) begin
				lat[g] <= gps_rst_val(g);
			end else if (wr_grp && gi == 4'(g)) begin
				lat[g] <= PWDATA[3:0] & gps_mask(g);
			end else if (wr_set && op_grp == 4'(g)) begin
				// Bits outside the group's width stay clear
				lat[g][op_bit] <= |(gps_mask(g) & (4'h1 << op_bit));
			end else if (wr_clr && op_grp == 4'(g)) begin
				lat[g][op_bit] <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			alt <= ALT_RESET;
			test_sel <= SEL_RESET;
		end else begin
			if (wr && is_alt) begin
				alt <= PWDATA[3:0];
			end
			if (wr && is_tst) begin
				test_sel <= {op_bit, op_grp};
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; second stage is the only reader of the first

	always_ff @(posedge CLOCK) begin
		pin_s1 <= BIDIR_IN;
		pin_s2 <= pin_s1;
		zc_s1 <= ZC_IN;
		zc_s2 <= zc_s1;
	end

	//////////////////////////////////////////////////////////////////////////
	// Pin drivers

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			BIDIR_OUT <= '0;
			BIDIR_OE <= '0;
			OUT_OUT <= '0;
			OUT_OE <= '0;
		end else begin
			for (int g = 0; g < GPS_NBIDIR; g++) begin
				if (gps_is_lv(g)) begin
					// N-channel sink: a one releases the pin
					BIDIR_OUT[g*4 +: 4] <= 4'h0;
					BIDIR_OE[g*4 +: 4] <= ~eff[g*4 +: 4];
				end else begin
					// P-channel source: a zero leaves the pull-down
					BIDIR_OUT[g*4 +: 4] <= 4'hF;
					BIDIR_OE[g*4 +: 4] <= eff[g*4 +: 4];
				end
			end
			for (int g = GPS_NBIDIR; g < GPS_NGRP - 1; g++) begin
				OUT_OUT[(g-GPS_NBIDIR)*4 +: 4] <= 4'hF;
				OUT_OE[(g-GPS_NBIDIR)*4 +: 4] <= lat[g];
			end
			OUT_OUT[20] <= 1'b1;
			OUT_OE[20] <= lat[GRP_SINGLE][0];
		end
	end

	// Pull choice is a mask option, held constant
	always_ff @(posedge CLOCK) begin
		BIDIR_PULL <= BIDIR_PULL_OPT;
		OUT_PULL <= OUT_PULL_OPT;
	end

	//////////////////////////////////////////////////////////////////////////
	// Shared pin functions

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			EXT_IRQ0 <= 1'b0;
			EXT_IRQ1 <= 1'b0;
			SER_SI <= 1'b0;
			STANDBY_REL <= 1'b0;
			ANALOG_FREE <= 8'h00;
		end else begin
			EXT_IRQ0 <= first_ext_irq_pin_src;
			EXT_IRQ1 <= pin_s2[3];
			SER_SI <= pin_s2[16];
			STANDBY_REL <= pin_s2[7];
			// Analog use needs the sink off and no peripheral
			ANALOG_FREE <= {lat[1][3],
				~alt[ALT_SQR] & lat[1][2],
				~alt[ALT_PWM_WIDE] & lat[1][1],
				~alt[ALT_PWM6] & lat[1][0],
				lat[0]};
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// APB answer: one wait state so read data comes from a flop

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h00000000;
		end else if (PSEL && PENABLE && !PREADY) begin
			PREADY <= 1'b1;
			PSLVERR <= ~mapped;
			if (PWRITE || !mapped) begin
				PRDATA <= 32'h00000000;
			end else if (is_grp) begin
				PRDATA <= {28'h0000000, grp_rd};
			end else if (is_tst) begin
				PRDATA <= {30'h0, ~test_bit, test_bit};
			end else if (is_alt) begin
				PRDATA <= {28'h0000000, alt};
			end else begin
				PRDATA <= {26'h0, test_sel};
			end
		end else begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	property p_nib_a;
		(wr && off == 8'h00) |=> ##1 BIDIR_OE[3:0] == ~$past(PWDATA[3:0], 2);
	endproperty
	a_nib_a: assert property (p_nib_a) else $error("nibble A drive");

	property p_set_c;
		(wr_set && op_grp == GRP_C && op_bit == 2'd1) |=>
			lat[2][1] && lat[2][3:2] == $past(lat[2][3:2]);
	endproperty
	a_set_c: assert property (p_set_c) else $error("bit set C");

	property p_clr_d;
		(wr_clr && op_grp == GRP_D && op_bit == 2'd3) |=>
			!lat[3][3] && lat[3][2:0] == $past(lat[3][2:0]);
	endproperty
	a_clr_d: assert property (p_clr_d) else $error("bit clear D");

	property p_test;
		(PSEL && PENABLE && !PREADY && !PWRITE && is_tst) |=>
			PREADY && PRDATA[0] == $past(test_bit) &&
			PRDATA[1] == !$past(test_bit);
	endproperty
	a_test: assert property (p_test) else $error("bit test");

	property p_rst_lv;
		@(posedge CLOCK) disable iff (1'b0)
		RST |=> lat[0] == LV_RESET && lat[1] == LV_RESET &&
			lat[4] == LV_RESET;
	endproperty
	a_rst_lv: assert property (p_rst_lv) else $error("lv reset");

	property p_rst_hv;
		@(posedge CLOCK) disable iff (1'b0)
		RST |=> lat[2] == {4{CD_RESET_HIGH}} && lat[3] == {4{CD_RESET_HIGH}};
	endproperty
	a_rst_hv: assert property (p_rst_hv) else $error("hv reset");

	property p_rst_out;
		@(posedge CLOCK) disable iff (1'b0)
		RST[*2] |=> OUT_OE == 21'h00000 && lat[GRP_K] == OUT_RESET;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("out reset");

	property p_k_nib;
		(wr_grp && gi == GRP_K) |=> ##1 OUT_OE[3:0] == $past(PWDATA[3:0], 2);
	endproperty
	a_k_nib: assert property (p_k_nib) else $error("nibble K");

	property p_single;
		(wr_grp && gi == GRP_SINGLE) |=> lat[GRP_SINGLE][3:1] == 3'b000;
	endproperty
	a_single: assert property (p_single) else $error("single bit");

	property p_rd_out;
		(PSEL && PENABLE && !PREADY && !PWRITE && is_grp && gi >= GRP_K &&
			gi <= GRP_SINGLE) |=> PRDATA[3:0] == $past(lat[gi] &
			((gi == GRP_SINGLE) ? SINGLE_MASK : NIB_MASK));
	endproperty
	a_rd_out: assert property (p_rd_out) else $error("latch read");

	property p_first_ext_irq_pin;
		(!ZC_SEL && BIDIR_IN[19])[*4] |-> EXT_IRQ0;
	endproperty
	a_first_ext_irq_pin: assert property (p_first_ext_irq_pin) else $error("first_ext_irq_pin route");

	property p_so;
		(alt[ALT_SER] && !SER_SO)[*2] |-> BIDIR_OE[17];
	endproperty
	a_so: assert property (p_so) else $error("serial out");

endmodule : gps_port_set

// ### bench/gps_ext_model.sv
// External switches and pull resistors on the bidirectional pins
module gps_ext_model (
	input wire logic CLOCK,
	input wire logic [19:0] bidir_out,
	input wire logic [19:0] bidir_oe,
	input wire logic [19:0] bidir_pull,
	input wire logic [19:0] ext_en,
	input wire logic [19:0] ext_val,
	output logic [19:0] pad
);
	timeunit 1ns;
	timeprecision 100ps;
	// A floating pin toggles so a stale value can never pass
	logic toggle = 1'b0;
	always @(posedge CLOCK) begin
		toggle <= ~toggle;
	end
	always_comb begin
		for (int i = 0; i < 20; i++) begin
			if (bidir_oe[i]) begin
				pad[i] = bidir_out[i];
			end else if (ext_en[i]) begin
				pad[i] = ext_val[i];
			end else if (bidir_pull[i]) begin
				pad[i] = (i < 8 || i > 15);
			end else begin
				pad[i] = toggle;
			end
		end
	end
endmodule : gps_ext_model

// ### bench/gps_port_set_tb.sv
// Self-checking bench for the port set block
module gps_port_set_tb;
	import gps_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [19:0] BPO = 20'hF5AFF;
	localparam logic [20:0] OPO = 21'h12345;
	logic CLOCK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [7:0] PADDR, ANALOG_FREE;
	logic [31:0] PWDATA, PRDATA;
	logic [19:0] BIDIR_IN, BIDIR_OUT, BIDIR_OE, BIDIR_PULL, ext_en, ext_val;
	logic [20:0] OUT_OUT, OUT_OE, OUT_PULL;
	logic ZC_IN, PWM6, PWM_WIDE, SQR_WAVE, SER_SO, SER_SCK;
	logic SER_SI, EXT_IRQ0, EXT_IRQ1, STANDBY_REL;
	int mismatches = 0;
	int n_tests = 0;
	//////////////////////////////////////////////////////////////////////////
	gps_port_set #(.CD_RESET_HIGH(1'b1), .BIDIR_PULL_OPT(BPO),
		.OUT_PULL_OPT(OPO), .ZC_SEL(1'b0)) uut (.CLOCK, .RST, .PSEL,
		.PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
		.BIDIR_IN, .BIDIR_OUT, .BIDIR_OE, .BIDIR_PULL, .OUT_OUT, .OUT_OE,
		.OUT_PULL, .ZC_IN, .PWM6, .PWM_WIDE, .SQR_WAVE, .SER_SO, .SER_SCK,
		.SER_SI, .EXT_IRQ0, .EXT_IRQ1, .STANDBY_REL, .ANALOG_FREE);
	gps_ext_model ext (.CLOCK, .bidir_out(BIDIR_OUT), .bidir_oe(BIDIR_OE),
		.bidir_pull(BIDIR_PULL), .ext_en, .ext_val, .pad(BIDIR_IN));
	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end
	//////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		do @(posedge CLOCK); while (PREADY !== 1'b1);
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLOCK);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
		repeat (3) @(posedge CLOCK);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask : rd
	//////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] q;
		chk("bidir_oe", 32'h0FF00, {12'h0, BIDIR_OE});
		chk("out_oe", 32'h0, {11'h0, OUT_OE});
		chk("bidir_pull", {12'h0, BPO}, {12'h0, BIDIR_PULL});
		chk("out_pull", {11'h0, OPO}, {11'h0, OUT_PULL});
		rd({2'h0, GRP_C, 2'h0}, q);
		chk("grp_c", 32'hF, q);
		rd({2'h0, GRP_A, 2'h0}, q);
		chk("grp_a", 32'hF, q);
		chk("analog_free", 32'hFF, {24'h0, ANALOG_FREE});
	endtask : t_reset
	task automatic t_nibble();
		logic [31:0] q;
		wr({2'h0, GRP_A, 2'h0}, 32'h5);
		chk("oe_a", 32'hA, {28'h0, BIDIR_OE[3:0]});
		rd({2'h0, GRP_A, 2'h0}, q);
		chk("grp_a", 32'h5, q);
		// Pins must settle through the synchroniser before the read
		ext_en[3:0] <= 4'hF;
		ext_val[3:0] <= 4'h6;
		wr({2'h0, GRP_A, 2'h0}, 32'hF);
		rd({2'h0, GRP_A, 2'h0}, q);
		chk("grp_a", 32'h6, q);
		chk("irq1", 32'h0, {31'h0, EXT_IRQ1});
		ext_en[3:0] <= 4'h0;
	endtask : t_nibble
	task automatic t_bits();
		logic [31:0] q;
		logic [3:0] m;
		for (int g = 1; g < 11; g++) begin
			if (g < 2 || g > 4) begin
				m = (g == 10) ? SINGLE_MASK : NIB_MASK;
				wr({2'h0, 4'(g), 2'h0}, 32'hA);
				wr(ADDR_BIT_SET, {26'h0, 2'd0, 4'(g)});
				wr(ADDR_BIT_CLR, {26'h0, 2'd1, 4'(g)});
				rd({2'h0, 4'(g), 2'h0}, q);
				chk("latch", {28'h0, 4'h9 & m}, q);
				if (g > 4) begin
					chk("out_oe", {28'h0, 4'h9 & m},
						{28'h0, 4'(OUT_OE >> ((g - 5) * 4)) & m});
				end
			end
		end
	endtask : t_bits
	task automatic t_test();
		logic [31:0] q;
		wr({2'h0, GRP_B, 2'h0}, 32'hF);
		ext_en[7:4] <= 4'hF;
		ext_val[7:4] <= 4'h2;
		wr(ADDR_BIT_TEST, {26'h0, 2'd1, GRP_B});
		rd(ADDR_BIT_TEST, q);
		chk("test_set", 32'h1, q);
		wr(ADDR_BIT_TEST, {26'h0, 2'd0, GRP_B});
		rd(ADDR_BIT_TEST, q);
		chk("test_clr", 32'h2, q);
		chk("standby_rel", 32'h0, {31'h0, STANDBY_REL});
		ext_en[7:4] <= 4'h0;
	endtask : t_test
	task automatic t_alt();
		logic [31:0] q;
		PWM6 <= 1'b1;
		SQR_WAVE <= 1'b1;
		SER_SCK <= 1'b1;
		ext_en[19:16] <= 4'h9;
		wr(ADDR_ALT_CTRL, 32'hF);
		chk("pads_b", 32'h5, {29'h0, BIDIR_IN[6:4]});
		chk("pads_f", 32'h2, {30'h0, BIDIR_IN[18:17]});
		chk("analog_free", 32'h8F, {24'h0, ANALOG_FREE});
		chk("ser_si", 32'h0, {31'h0, SER_SI});
		chk("irq0", 32'h0, {31'h0, EXT_IRQ0});
		PWM6 <= 1'b0;
		PWM_WIDE <= 1'b1;
		SQR_WAVE <= 1'b0;
		SER_SO <= 1'b1;
		SER_SCK <= 1'b0;
		ext_val[19:16] <= 4'h9;
		rd(ADDR_ALT_CTRL, q);
		chk("alt_ctrl", 32'hF, q);
		chk("pads_b", 32'h2, {29'h0, BIDIR_IN[6:4]});
		chk("pads_f", 32'h1, {30'h0, BIDIR_IN[18:17]});
		chk("irq0", 32'h1, {31'h0, EXT_IRQ0});
	endtask : t_alt
	task automatic t_err();
		logic [31:0] q;
		logic e;
		apb(1'b0, 8'h80, 32'h0, q, e);
		chk("pslverr", 32'h1, {31'h0, e});
		chk("prdata", 32'h0, q);
	endtask : t_err
	task automatic t_hv();
		wr({2'h0, GRP_C, 2'h0}, 32'h0);
		wr(ADDR_BIT_SET, {26'h0, 2'd1, GRP_C});
		chk("oe_c", 32'h2, {28'h0, BIDIR_OE[11:8]});
		chk("pad_c3", 32'h0, {31'h0, BIDIR_IN[11]});
		wr(ADDR_BIT_CLR, {26'h0, 2'd3, GRP_D});
		chk("oe_d", 32'h7, {28'h0, BIDIR_OE[15:12]});
	endtask : t_hv
	task automatic t_rerst();
		RST <= 1'b1;
		repeat (2) @(posedge CLOCK);
		RST <= 1'b0;
		repeat (2) @(posedge CLOCK);
		chk("bidir_oe", 32'h0FF00, {12'h0, BIDIR_OE});
		chk("out_oe", 32'h0, {11'h0, OUT_OE});
		chk("analog_free", 32'hFF, {24'h0, ANALOG_FREE});
	endtask : t_rerst
	//////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("Counts: %0d mismatches in %0d tests", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		{ZC_IN, PWM6, PWM_WIDE, SQR_WAVE, SER_SO, SER_SCK} = '0;
		ext_en = '0;
		ext_val = '0;
		RST = 1'b1;
		repeat (20) @(posedge CLOCK);
		RST <= 1'b0;
		repeat (2) @(posedge CLOCK);
		t_reset();
		t_nibble();
		t_bits();
		t_hv();
		t_test();
		t_alt();
		t_err();
		t_rerst();
		end_of_test();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge CLOCK);
		mismatches++;
		end_of_test();
	end
endmodule : gps_port_set_tb
